// file: tw_ctl.sv
// two-wire controller: start/stop, own address match, scl timing, enable
// Summary of operation
// - with stall-after-start enabled, master sets start stall flag after a start
// - stop seen on bus while addressed slave sets slave stop flag
// - writing one to stop while master generates a stop condition
// - hardware clears the stop bit once the stop is on the bus
// - start bit clears after the start is sent or on bus error
// - a non-master waits for the bus to be free, then starts
// - an active master starts only after start then a data write
// - start during a transfer gives a repeated start, no stop between
// - own address enable at zero means no address compare
// - first seven bits after start compare against address bits 6 down to 0
// - match only if seven bits equal address and enable is one
// - master holds scl low and high each twice divisor module clocks
// - enable zero clears first control and status registers and all cstat bits but the sda level, halts clocks
// - second control register resets to zero, block disabled
// - interrupt events reach the output only with interrupt enable set
// - with stall-after-start, bus stalls after address byte until software acts
`timescale 1ns/1ps
module tw_ctl (
    input wire logic mclk,
    input wire logic rst_n,
    input wire tw_pkg::tw_bus_req_t bus,
    output logic [7:0] rdata,
    output logic irq,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    import tw_pkg::*;

    logic [1:0] rs_q;
    logic rst_s_n;
    logic scl_s;
    logic sda_s;
    logic tick;
    logic run;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    tw_ctl_st_t q;
    tw_ctl_st_t d;
    tw_stat_t st_w1c;
    tw_ctl1_t c1_w;
    logic [7:0] cstat;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rs_q <= 2'h0;
        else
            rs_q <= {rs_q[0], 1'b1};
    end
    assign rst_s_n = rs_q[1];

    tw_sync u_sync (
        .mclk(mclk),
        .rst_s_n(rst_s_n),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .scl_s(scl_s),
        .sda_s(sda_s)
    );

    // timer only runs in the timed master phases; halted when disabled
    assign run = q.c2.enable && (q.ms != M_IDLE) && (q.ms != M_WAIT) && (q.ms != M_HOLD);

    tw_sclgen u_gen (
        .mclk(mclk),
        .rst_s_n(rst_s_n),
        .run(run),
        .div(q.c2.clock_divisor),
        .tick(tick)
    );

    assign start_det = scl_s && q.scl_p && q.sda_p && !sda_s;
    assign stop_det = scl_s && q.scl_p && !q.sda_p && sda_s;
    assign scl_rise = scl_s && !q.scl_p;
    assign st_w1c = tw_stat_t'(bus.wdata & TW_STAT_W1C);
    assign c1_w = tw_ctl1_t'(bus.wdata);
    assign cstat = {2'h0, 1'b0, sda_s, 1'b0, q.match, q.bus_busy_flag, q.st.master || q.sl_act};

    always_comb
    begin
        d = q;
        d.lo = 1'b0;
        d.scl_p = scl_s;
        d.sda_p = sda_s;

        // software writes first, so hardware sets below win over clears
        if (bus.wr)
        begin
            if (bus.addr == TW_OFS_DATA)
            begin
                d.dat = bus.wdata;
                d.dwr = 1'b1;
                d.st.sdast = 1'b0;
            end
            else if (bus.addr == TW_OFS_STAT)
            begin
                d.st = q.st & ~st_w1c;
            end
            else if (bus.addr == TW_OFS_CTL1)
            begin
                d.c1 = c1_w;
                d.c1.rsvd = 1'b0;
                // start and stop are only set by software, cleared by hardware
                d.c1.stop = q.c1.stop | c1_w.stop;
                d.c1.start = q.c1.start | c1_w.start;
            end
            else if (bus.addr == TW_OFS_ADDR)
            begin
                d.ad = tw_addr_t'(bus.wdata);
            end
            else if (bus.addr == TW_OFS_CTL2)
            begin
                d.c2 = tw_ctl2_t'(bus.wdata);
            end
        end

        if (start_det)
            d.bus_busy_flag = 1'b1;
        if (stop_det)
            d.bus_busy_flag = 1'b0;

        // slave address capture
        if (start_det && !q.st.master)
        begin
            d.sl_act = 1'b1;
            d.scnt = 3'h0;
            d.match = 1'b0;
        end
        else if (q.sl_act && q.scnt == TW_ADDR_BITS)
        begin
            // the direction bit is never shifted in
            d.sl_act = 1'b0;
            if (q.ad.own_address_enable && q.ssh == q.ad.addr)
            begin
                d.match = 1'b1;
                d.st.nmatch = 1'b1;
            end
        end
        else if (q.sl_act && scl_rise)
        begin
            // msb first: first bit lands in bit 6
            d.ssh = {q.ssh[5:0], sda_s};
            d.scnt = q.scnt + 3'h1;
        end

        if (stop_det)
        begin
            d.sl_act = 1'b0;
            if (!q.st.master && q.match)
            begin
                d.st.slave_stop_flag = 1'b1;
                d.match = 1'b0;
            end
        end

        // a stop request with no bus ownership has nothing to end
        if (q.c1.stop && !q.st.master && q.ms == M_IDLE)
            d.c1.stop = 1'b0;

        case (q.ms)
            M_IDLE:
            begin
                if (q.c1.start && !q.st.master)
                    d.ms = M_WAIT;
            end
            M_WAIT:
            begin
                if (!q.bus_busy_flag)
                begin
                    d.ms = M_START;
                    d.sda_oe = 1'b1;
                end
            end
            M_START:
            begin
                if (tick)
                begin
                    d.c1.start = 1'b0;
                    d.st.master = 1'b1;
                    d.st.xmit = 1'b1;
                    d.scl_oe = 1'b1;
                    d.first = 1'b1;
                    d.ms = M_HOLD;
                end
            end
            M_HOLD:
            begin
                // scl held low here; a set stall flag keeps the bus stalled
                if (q.c1.stop)
                begin
                    d.ms = M_STOP_A;
                    d.sda_oe = 1'b1;
                    // a pending byte must not leak into the next message
                    d.dwr = 1'b0;
                end
                else if (q.dwr && !q.st.start_stall_flag)
                begin
                    if (q.c1.start)
                    begin
                        // byte stays pending and goes out after the repeated start
                        d.ms = M_RS_A;
                        d.sda_oe = 1'b0;
                    end
                    else
                    begin
                        d.dwr = 1'b0;
                        d.ms = M_LOW;
                        d.bcnt = 4'h0;
                        d.sda_oe = !q.dat[7];
                    end
                end
            end
            M_LOW:
            begin
                if (tick)
                begin
                    d.scl_oe = 1'b0;
                    d.ms = M_HIGH;
                end
            end
            M_HIGH:
            begin
                if (tick)
                begin
                    // sda moves on the same edge scl goes low; slaves sample on rise
                    d.scl_oe = 1'b1;
                    if (q.bcnt == TW_ACK_BIT)
                    begin
                        d.ms = M_HOLD;
                        d.sda_oe = 1'b0;
                        d.st.sdast = 1'b1;
                        if (sda_s)
                            d.st.negack = 1'b1;
                        if (q.first && q.c1.stall_after_start_enable)
                            d.st.start_stall_flag = 1'b1;
                        d.first = 1'b0;
                    end
                    else
                    begin
                        d.dat = {q.dat[6:0], sda_s};
                        d.bcnt = q.bcnt + 4'h1;
                        d.sda_oe = (q.bcnt == TW_LAST_DATA_BIT) ? 1'b0 : !q.dat[6];
                        d.ms = M_LOW;
                    end
                end
            end
            M_RS_A:
            begin
                if (tick)
                begin
                    d.scl_oe = 1'b0;
                    d.ms = M_RS_B;
                end
            end
            M_RS_B:
            begin
                if (tick)
                begin
                    // sda falls while scl high: repeated start, no stop
                    d.sda_oe = 1'b1;
                    d.ms = M_START;
                end
            end
            M_STOP_A:
            begin
                if (tick)
                begin
                    d.scl_oe = 1'b0;
                    d.ms = M_STOP_B;
                end
            end
            M_STOP_B:
            begin
                if (tick)
                begin
                    d.sda_oe = 1'b0;
                    d.ms = M_STOP_C;
                end
            end
            M_STOP_C:
            begin
                if (tick)
                begin
                    d.c1.stop = 1'b0;
                    d.st.master = 1'b0;
                    d.st.xmit = 1'b0;
                    d.ms = M_IDLE;
                end
            end
            default:
            begin
                d.ms = M_IDLE;
            end
        endcase

        // foreign start or stop in the middle of our byte
        if ((start_det || stop_det) && (q.ms == M_LOW || q.ms == M_HIGH))
        begin
            d.st.bus_error_flag = 1'b1;
            d.c1.start = 1'b0;
            d.st.master = 1'b0;
            d.st.xmit = 1'b0;
            d.scl_oe = 1'b0;
            d.sda_oe = 1'b0;
            d.ms = M_IDLE;
        end

        if (!d.c2.enable)
        begin
            d.c1 = tw_ctl1_t'(TW_CTL1_RST);
            d.st = tw_stat_t'(TW_STAT_RST);
            d.match = 1'b0;
            d.bus_busy_flag = 1'b0;
            d.ms = M_IDLE;
            d.scl_oe = 1'b0;
            d.sda_oe = 1'b0;
            d.sl_act = 1'b0;
            d.dwr = 1'b0;
            d.first = 1'b0;
        end

        d.irq = d.c1.interrupt_enable_bit && (d.st.start_stall_flag ||
            d.st.slave_stop_flag || d.st.bus_error_flag || d.st.negack ||
            d.st.sdast || (d.st.nmatch && d.c1.new_match_int_enable));

        d.rdata = 8'h00;
        if (bus.rd)
        begin
            if (bus.addr == TW_OFS_DATA)
                d.rdata = q.dat;
            else if (bus.addr == TW_OFS_STAT)
                d.rdata = q.st;
            else if (bus.addr == TW_OFS_CSTAT)
                d.rdata = cstat;
            else if (bus.addr == TW_OFS_CTL1)
                d.rdata = q.c1;
            else if (bus.addr == TW_OFS_ADDR)
                d.rdata = q.ad;
            else if (bus.addr == TW_OFS_CTL2)
                d.rdata = q.c2;
        end
    end

    // own address has no defined reset value; zero is used here
    always_ff @(posedge mclk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            q <= '0;
            q.c1 <= tw_ctl1_t'(TW_CTL1_RST);
            q.st <= tw_stat_t'(TW_STAT_RST);
            q.ad <= tw_addr_t'(TW_ADDR_RST);
            q.c2 <= tw_ctl2_t'(TW_CTL2_RST);
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign irq = q.irq;
    assign scl_o = q.lo;
    assign sda_o = q.lo;
    assign scl_oe = q.scl_oe;
    assign sda_oe = q.sda_oe;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_s_n);

    start_stall_a: assert property ($rose(q.st.start_stall_flag) |->
        $past(q.c1.stall_after_start_enable) && $past(q.ms) == M_HIGH && $past(q.first))
        else $error("start stall flag set without stall enable");

    slave_stop_a: assert property ($rose(q.st.slave_stop_flag) |->
        $past(stop_det) && !$past(q.st.master) && $past(q.match))
        else $error("slave stop flag set without a stop as slave");

    stop_clear_a: assert property ($fell(q.c1.stop) |->
        $past(q.ms) == M_STOP_C || !$past(q.st.master) || !q.c2.enable)
        else $error("stop bit cleared before the stop was issued");

    start_clear_a: assert property ($fell(q.c1.start) |->
        $past(q.ms) == M_START || q.st.bus_error_flag || !q.c2.enable)
        else $error("start bit cleared without start or bus error");

    wait_free_a: assert property ($past(q.ms) == M_WAIT && q.ms == M_START |->
        !$past(q.bus_busy_flag) && q.sda_oe && !q.scl_oe)
        else $error("start issued while bus busy");

    addr_match_a: assert property ($rose(q.match) |->
        $past(q.ad.own_address_enable) && $past(q.ssh) == $past(q.ad.addr))
        else $error("address match without equal enabled address");

    irq_gate_a: assert property (q.irq |-> $past(q.c1.interrupt_enable_bit) ||
        q.c1.interrupt_enable_bit)
        else $error("interrupt raised with interrupt enable clear");

    disable_clear_a: assert property (!q.c2.enable |->
        q.st == tw_stat_t'(TW_STAT_RST) && q.c1 == tw_ctl1_t'(TW_CTL1_RST) && !run)
        else $error("disabled block keeps control or status state");

    rep_start_a: assert property ($past(q.ms) == M_RS_B && q.ms == M_START |->
        q.st.master && !q.scl_oe ##1 q.st.master)
        else $error("repeated start lost bus ownership");
endmodule // tw_ctl

// file: tw_pkg.sv
// shared constants and types of the two-wire control block
package tw_pkg;

    // register offsets
    localparam logic [2:0] TW_OFS_DATA = 3'h0;
    localparam logic [2:0] TW_OFS_STAT = 3'h1;
    localparam logic [2:0] TW_OFS_CSTAT = 3'h2;
    localparam logic [2:0] TW_OFS_CTL1 = 3'h3;
    localparam logic [2:0] TW_OFS_ADDR = 3'h4;
    localparam logic [2:0] TW_OFS_CTL2 = 3'h5;

    // reset values
    localparam logic [7:0] TW_CTL1_RST = 8'h00;
    localparam logic [7:0] TW_CTL2_RST = 8'h00;
    localparam logic [7:0] TW_ADDR_RST = 8'h00;
    localparam logic [7:0] TW_STAT_RST = 8'h00;

    // status bits that software clears by writing one
    localparam logic [7:0] TW_STAT_W1C = 8'hBC;

    // scl phase is this many times the divisor in module clocks
    localparam int TW_SCL_MULT = 2;
    localparam logic [3:0] TW_ACK_BIT = 4'h8;
    localparam logic [3:0] TW_LAST_DATA_BIT = 4'h7;
    localparam logic [2:0] TW_ADDR_BITS = 3'h7;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tw_bus_req_t;

    typedef struct packed {
        logic stall_after_start_enable;
        logic new_match_int_enable;
        logic global_call_enable;
        logic ack;
        logic rsvd;
        logic interrupt_enable_bit;
        logic stop;
        logic start;
    } tw_ctl1_t;

    typedef struct packed {
        logic slave_stop_flag;
        logic sdast;
        logic bus_error_flag;
        logic negack;
        logic start_stall_flag;
        logic nmatch;
        logic master;
        logic xmit;
    } tw_stat_t;

    typedef struct packed {
        logic own_address_enable;
        logic [6:0] addr;
    } tw_addr_t;

    typedef struct packed {
        logic [6:0] clock_divisor;
        logic enable;
    } tw_ctl2_t;

    typedef enum logic [3:0] {
        M_IDLE, M_WAIT, M_START, M_LOW, M_HIGH, M_HOLD,
        M_RS_A, M_RS_B, M_STOP_A, M_STOP_B, M_STOP_C
    } tw_mst_t;

    typedef struct packed {
        tw_mst_t ms;
        tw_ctl1_t c1;
        tw_stat_t st;
        tw_addr_t ad;
        tw_ctl2_t c2;
        logic match;
        logic bus_busy_flag;
        logic [7:0] dat;
        logic [3:0] bcnt;
        logic first;
        logic dwr;
        logic sl_act;
        logic [2:0] scnt;
        logic [6:0] ssh;
        logic scl_p;
        logic sda_p;
        logic scl_oe;
        logic sda_oe;
        logic lo;
        logic irq;
        logic [7:0] rdata;
    } tw_ctl_st_t;

    typedef struct packed {
        logic [8:0] cnt;
        logic [8:0] gap;
    } tw_gen_st_t;

endpackage

// file: tw_sync.sv
// two-flop synchroniser for the scl and sda pin levels
`timescale 1ns/1ps
module tw_sync (
    input wire logic mclk,
    input wire logic rst_s_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_s,
    output logic sda_s
);
    logic [1:0] meta_q;
    logic [1:0] sync_q;

    // pins idle high, so reset to the released level
    always_ff @(posedge mclk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            meta_q <= 2'h3;
            sync_q <= 2'h3;
        end
        else
        begin
            meta_q <= {scl_i, sda_i};
            sync_q <= meta_q;
        end
    end

    assign scl_s = sync_q[1];
    assign sda_s = sync_q[0];
endmodule // tw_sync

// file: tw_sclgen.sv
// scl phase timer: one tick per phase of the master clock
`timescale 1ns/1ps
module tw_sclgen (
    input wire logic mclk,
    input wire logic rst_s_n,
    input wire logic run,
    input wire logic [6:0] div,
    output logic tick
);
    import tw_pkg::*;

    tw_gen_st_t q;
    tw_gen_st_t d;
    logic [8:0] lim;

    assign lim = 9'(TW_SCL_MULT * div) - 9'h001;
    assign tick = run && (q.cnt == lim);

    // counter held at zero while idle so every phase starts full length
    always_comb
    begin
        d = q;
        if (!run || tick)
        begin
            d.cnt = 9'h000;
            d.gap = 9'h000;
        end
        else
        begin
            d.cnt = q.cnt + 9'h001;
            d.gap = q.gap + 9'h001;
        end
    end

    always_ff @(posedge mclk or negedge rst_s_n)
    begin
        if (!rst_s_n)
            q <= '0;
        else
            q <= d;
    end

    phase_len_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        tick |-> q.gap == {1'b0, div, 1'b0} - 9'h001)
        else $error("scl phase length differs from twice the divisor");
endmodule // tw_sclgen

// file: tw_peer.sv
// behavioural foreign master on the two-wire bus
`timescale 1ns/1ps
module tw_peer (
    output logic scl_oe,
    output logic sda_oe
);
    // half of the 48 ns link clock period
    localparam int HALF = 24;
    initial
    begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // one clock of the frame: data changes only while scl is low
    task automatic put(input logic b);
        scl_oe = 1'b1;
        #(HALF / 2) sda_oe = ~b;
        #(HALF / 2) scl_oe = 1'b0;
        #HALF;
    endtask
    // clock stands still outside frames, both lines released to the pull-up
    task automatic frame(input logic [7:0] b);
        sda_oe = 1'b1;
        #HALF;
        for (int i = 7; i >= 0; i--)
        begin
            put(b[i]);
        end
        // ack slot left released: the block's slave side never acks
        put(1'b1);
        put(1'b0);
        sda_oe = 1'b0;
        #HALF;
    endtask
endmodule // tw_peer

// file: twowire_start_stop_addr_clock_test.sv
// self-checking bench for the two-wire control block
`timescale 1ns/1ps
module twowire_start_stop_addr_clock_test;
    import tw_pkg::*;
    localparam int PH = 2 * 8;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    tw_bus_req_t bus = '0;
    logic [7:0] rdata;
    logic [7:0] d;
    logic irq, scl_o, sda_o, d_scl_oe, d_sda_oe, p_scl_oe, p_sda_oe, scl, sda;
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    logic [8:0] sh = 9'h000;
    int err_total = 0;
    int n_compared = 0;
    int n_start = 0;
    int n_stop = 0;
    int lo_n = 0;
    int hi_n = 0;
    int lo_last = 0;
    int hi_last = 0;
    int cyc = 0;

    always #2.5 mclk = ~mclk;
    // open-drain wires with pull-ups
    assign scl = ~(d_scl_oe | p_scl_oe);
    assign sda = ~(d_sda_oe | p_sda_oe);

    tw_ctl i_dut (
        .mclk(mclk),
        .rst_n(rst_n),
        .bus(bus),
        .rdata(rdata),
        .irq(irq),
        .scl_i(scl),
        .scl_o(scl_o),
        .scl_oe(d_scl_oe),
        .sda_i(sda),
        .sda_o(sda_o),
        .sda_oe(d_sda_oe)
    );
    tw_peer i_peer (
        .scl_oe(p_scl_oe),
        .sda_oe(p_sda_oe)
    );

    task automatic end_of_test();
        $display("compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // wire watcher: start/stop events, shifted bits, phase lengths
    always @(posedge mclk)
    begin
        scl_q <= scl;
        sda_q <= sda;
        if (scl && scl_q && sda_q && !sda)
            n_start <= n_start + 1;
        if (scl && scl_q && !sda_q && sda)
            n_stop <= n_stop + 1;
        if (scl && !scl_q)
            sh <= {sh[7:0], sda};
        if (scl && !scl_q)
            lo_last <= lo_n;
        if (!scl && scl_q)
            hi_last <= hi_n;
        lo_n <= scl ? 0 : lo_n + 1;
        hi_n <= scl ? hi_n + 1 : 0;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            end_of_test();
        end
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_n(input int got, input int exp);
        n_compared++;
        if (got != exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic poll(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        for (int i = 0; i < 300; i++)
        begin
            rd(a);
            if ((d & m) === e)
                break;
        end
        cmp8(d & m, e);
    endtask

    task automatic t_reset();
        rd(TW_OFS_CTL2);
        cmp8(d, 8'h00);
        wr(TW_OFS_CTL1, 8'h04);
        rd(TW_OFS_CTL1);
        cmp8(d, 8'h00);
        rd(3'h7);
        cmp8(d, 8'h00);
    endtask
    task automatic t_enable();
        wr(TW_OFS_CTL2, 8'h11);
        rd(TW_OFS_CTL2);
        cmp8(d, 8'h11);
        wr(TW_OFS_ADDR, 8'hAA);
        rd(TW_OFS_ADDR);
        cmp8(d, 8'hAA);
    endtask
    task automatic t_master();
        wr(TW_OFS_CTL1, 8'h85);
        poll(TW_OFS_CTL1, 8'h01, 8'h00);
        cmp_n(n_start, 1);
        rd(TW_OFS_CSTAT);
        cmp8(d & 8'h02, 8'h02);
        rd(TW_OFS_STAT);
        cmp8(d & 8'h02, 8'h02);
        wr(TW_OFS_DATA, 8'hA4);
        poll(TW_OFS_STAT, 8'h40, 8'h40);
        cmp8(sh[8:1], 8'hA4);
        cmp_n(lo_last, PH);
        cmp_n(hi_last, PH);
        rd(TW_OFS_STAT);
        cmp8(d & 8'h0A, 8'h0A);
        cmp8({7'h00, irq}, 8'h01);
        // a byte written while stalled must wait for the flag to clear
        wr(TW_OFS_DATA, 8'h3C);
        repeat (100) @(posedge mclk);
        #1 cmp8({7'h00, scl}, 8'h00);
        cmp8({6'h00, scl_o, d_scl_oe}, 8'h01);
        wr(TW_OFS_CTL1, 8'h80);
        repeat (2) @(posedge mclk);
        #1 cmp8({7'h00, irq}, 8'h00);
        wr(TW_OFS_STAT, 8'h08);
        poll(TW_OFS_STAT, 8'h48, 8'h40);
        cmp8(sh[8:1], 8'h3C);
    endtask
    task automatic t_rstart();
        wr(TW_OFS_CTL1, 8'h01);
        repeat (100) @(posedge mclk);
        cmp_n(n_start, 1);
        wr(TW_OFS_DATA, 8'h5A);
        poll(TW_OFS_STAT, 8'h40, 8'h40);
        cmp_n(n_start, 2);
        cmp_n(n_stop, 0);
        cmp8(sh[8:1], 8'h5A);
        wr(TW_OFS_STAT, 8'hBC);
    endtask
    task automatic t_stop();
        wr(TW_OFS_CTL1, 8'h02);
        poll(TW_OFS_CTL1, 8'h02, 8'h00);
        cmp_n(n_stop, 1);
        rd(TW_OFS_STAT);
        cmp8(d & 8'h02, 8'h00);
    endtask
    // 0x59 carries address 0x2C then a set direction bit
    task automatic t_slave(input logic [7:0] own, input logic [7:0] exp);
        wr(TW_OFS_ADDR, own);
        wr(TW_OFS_STAT, 8'hBC);
        i_peer.frame(8'h59);
        repeat (10) @(posedge mclk);
        rd(TW_OFS_STAT);
        cmp8(d & 8'h84, exp);
    endtask
    task automatic t_disable();
        wr(TW_OFS_CTL1, 8'h04);
        wr(TW_OFS_CTL2, 8'h10);
        rd(TW_OFS_STAT);
        cmp8(d, 8'h00);
        rd(TW_OFS_CTL1);
        cmp8(d, 8'h00);
    endtask

    initial
    begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset();
        t_enable();
        t_master();
        t_rstart();
        t_stop();
        t_slave(8'h2C, 8'h00);
        t_slave(8'hAD, 8'h00);
        t_slave(8'hAC, 8'h84);
        t_disable();
        end_of_test();
    end
endmodule // twowire_start_stop_addr_clock_test
